// ==== design/bps_sequencer.sv ====
// Purpose: fault protection, gate command and output-good sequencing
// Assumes: comparator results arrive as asynchronous digital levels
// Notes:   soft-start ramp itself is outside; this block pulses its restart
// Function
// - supply low stops switching, both gates off except in the over-voltage latch (low gate stays on); recovery resumes via soft start.
// - over-voltage held 10 us latches high gate off, low gate on.
// - under-voltage held 100 us latches both gates off.
// - voltage latches hold until enable drops and returns, then soft start.
// - high gate stays off while amplified sense exceeds valley limit.
// - high gate turns on again once sense falls below limit.
// - current limit never latches; switching continues, output droops.
// - thermal indication turns both gates off, except in the over-voltage latch, which keeps low gate on.
// - output discharge stays active throughout thermal shutdown.
// - thermal release restarts soft start without enable re-entry.
// - output-good released 50 us after output rises above threshold.
// - output-good pulled low 10 us after output falls below threshold.
// - dead time between one gate off and the other on, both ways.
module bps_sequencer
(
    // clock and reset
    input  wire logic  sys_clk,
    input  wire logic  reset_n,
    // control and comparator pins
    input  wire logic  enable,
    input  wire logic  supply_ok,
    input  wire logic  overvoltage_det,
    input  wire logic  undervoltage_det,
    input  wire logic  valley_current_limit,
    input  wire logic  thermal_shutdown,
    input  wire logic  output_above_good,
    // on-time generator request, same clock
    input  wire logic  pwm_high_req,
    // gate commands
    output wire logic  high_side_gate,
    output wire logic  low_side_gate,
    // soft start and discharge
    output wire logic  soft_start_restart,
    output wire logic  discharge_en,
    // output-good open drain
    output wire logic  output_good_flag_out,
    output wire logic  output_good_flag_oe_n,
    // status
    output wire logic  overvoltage_latch,
    output wire logic  undervoltage_latch
);
    logic                           rst_q1;
    logic                           rst_q2;
    logic                           rst_n;
    logic [bps_pkg::IN_W-1:0]       sync_q1;
    logic [bps_pkg::IN_W-1:0]       sync_q2;
    logic [bps_pkg::TICK_W-1:0]     tick_cnt_q;
    logic [bps_pkg::TICK_W-1:0]     tick_cnt_d;
    logic                           tick;
    bps_pkg::bps_state_type         state_q;
    bps_pkg::bps_state_type         state_d;
    logic [bps_pkg::QCNT_W-1:0]     ov_cnt_q;
    logic [bps_pkg::QCNT_W-1:0]     ov_cnt_d;
    logic [bps_pkg::QCNT_W-1:0]     uv_cnt_q;
    logic [bps_pkg::QCNT_W-1:0]     uv_cnt_d;
    logic [bps_pkg::QCNT_W-1:0]     pg_cnt_q;
    logic [bps_pkg::QCNT_W-1:0]     pg_cnt_d;
    logic [bps_pkg::QCNT_W-1:0]     pg_limit;
    logic                           pg_q;
    logic                           pg_d;
    logic                           start_q;
    logic                           start_d;
    logic                           dis_q;
    logic                           dis_d;
    logic                           en_s;
    logic                           sup_s;
    logic                           ov_s;
    logic                           uv_s;
    logic                           valley_current_limit_s;
    logic                           therm_s;
    logic                           pgc_s;
    logic                           run;

    bps_gate_if gate_if ();

    // qualification counter: counts ticks while active, clears otherwise
    function automatic logic [bps_pkg::QCNT_W-1:0] qual_next
    (
        input logic                          active,
        input logic [bps_pkg::QCNT_W-1:0]    cnt,
        input logic [bps_pkg::QCNT_W-1:0]    limit,
        input logic                          tk
    );
        logic [bps_pkg::QCNT_W-1:0] r;
        r = '0;
        if (active)
        begin
            r = (tk && (cnt < limit)) ? cnt + 1'b1 : cnt;
        end
        return r;
    endfunction

    // reset release through two flops
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_q1 <= 1'b0;
            rst_q2 <= 1'b0;
        end
        else
        begin
            rst_q1 <= 1'b1;
            rst_q2 <= rst_q1;
        end
    end
    assign rst_n = rst_q2;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_q1 <= '0;
            sync_q2 <= '0;
        end
        else
        begin
            sync_q1 <= {output_above_good, thermal_shutdown, valley_current_limit,
                        undervoltage_det, overvoltage_det, supply_ok, enable};
            sync_q2 <= sync_q1;
        end
    end

    always_comb
    begin
        en_s    = sync_q2[bps_pkg::IN_EN];
        sup_s   = sync_q2[bps_pkg::IN_SUPPLY];
        ov_s    = sync_q2[bps_pkg::IN_OV];
        uv_s    = sync_q2[bps_pkg::IN_UV];
        valley_current_limit_s  = sync_q2[bps_pkg::IN_VALLEY_CURRENT_LIMIT];
        therm_s = sync_q2[bps_pkg::IN_THERM];
        pgc_s   = sync_q2[bps_pkg::IN_PG];
        run     = (state_q == bps_pkg::ST_RUN);
    end

    // timebase, qualification counters and state
    always_comb
    begin
        tick = (tick_cnt_q == bps_pkg::TICK_W'(bps_pkg::TICK_CYC - 1));
        tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1;
        // restart on dropout; expiry waits one more tick, never short
        ov_cnt_d = qual_next(run & ov_s, ov_cnt_q, bps_pkg::OV_TICKS, tick);
        uv_cnt_d = qual_next(run & uv_s, uv_cnt_q, bps_pkg::UV_TICKS, tick);
        pg_limit = pg_q ? bps_pkg::PGF_TICKS : bps_pkg::PGR_TICKS;
        pg_cnt_d = qual_next(run & (pgc_s != pg_q), pg_cnt_q, pg_limit, tick);
        pg_d     = pg_q;
        if (!run)
        begin
            pg_d = 1'b0;
        end
        else if ((pgc_s != pg_q) && tick && (pg_cnt_q == pg_limit))
        begin
            pg_d     = pgc_s;
            pg_cnt_d = '0;
        end
        state_d = state_q;
        start_d = 1'b0;
        unique case (state_q)
            bps_pkg::ST_IDLE:
            begin
                if (en_s && !sup_s)
                    state_d = bps_pkg::ST_LOCKOUT;
                else if (en_s)
                begin
                    state_d = bps_pkg::ST_RUN;
                    start_d = 1'b1;
                end
            end
            bps_pkg::ST_LOCKOUT:
            begin
                if (!en_s)
                    state_d = bps_pkg::ST_IDLE;
                else if (sup_s)
                begin
                    state_d = bps_pkg::ST_RUN;
                    start_d = 1'b1;
                end
            end
            bps_pkg::ST_RUN:
            begin
                if (!en_s)
                    state_d = bps_pkg::ST_IDLE;
                else if (!sup_s)
                    state_d = bps_pkg::ST_LOCKOUT;
                else if (therm_s)
                    state_d = bps_pkg::ST_THERM;
                else if (ov_s && tick && (ov_cnt_q == bps_pkg::OV_TICKS))
                    state_d = bps_pkg::ST_OV;
                else if (uv_s && tick && (uv_cnt_q == bps_pkg::UV_TICKS))
                    state_d = bps_pkg::ST_UV;
            end
            bps_pkg::ST_OV, bps_pkg::ST_UV:
            begin
                // only enable removal clears the latch
                if (!en_s)
                    state_d = bps_pkg::ST_IDLE;
            end
            bps_pkg::ST_THERM:
            begin
                if (!en_s)
                    state_d = bps_pkg::ST_IDLE;
                else if (!sup_s)
                    state_d = bps_pkg::ST_LOCKOUT;
                else if (!therm_s)
                begin
                    state_d = bps_pkg::ST_RUN;
                    start_d = 1'b1;
                end
            end
            default:
                state_d = bps_pkg::ST_IDLE;
        endcase
        // discharge held for the whole thermal state
        dis_d = (state_d == bps_pkg::ST_THERM);
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt_q <= '0;
            ov_cnt_q   <= '0;
            uv_cnt_q   <= '0;
            pg_cnt_q   <= '0;
            pg_q       <= 1'b0;
            state_q    <= bps_pkg::ST_IDLE;
            start_q    <= 1'b0;
            dis_q      <= 1'b0;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_d;
            ov_cnt_q   <= ov_cnt_d;
            uv_cnt_q   <= uv_cnt_d;
            pg_cnt_q   <= pg_cnt_d;
            pg_q       <= pg_d;
            state_q    <= state_d;
            start_q    <= start_d;
            dis_q      <= dis_d;
        end
    end

    // gate requests per state
    always_comb
    begin
        gate_if.hs_req = 1'b0;
        gate_if.ls_req = 1'b0;
        if (run)
        begin
            // high side held off above the valley limit
            // released once sense drops below it
            // limiting only shapes switching, never stops it
            gate_if.hs_req = pwm_high_req & ~valley_current_limit_s;
            gate_if.ls_req = ~gate_if.hs_req;
        end
        // latched over-voltage keeps low side on
        else if (state_q == bps_pkg::ST_OV)
        begin
            gate_if.ls_req = 1'b1;
        end
    end

    bps_dead_time u_dead
    (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .g     (gate_if.dead)
    );

    assign high_side_gate        = gate_if.hs_gate;
    assign low_side_gate         = gate_if.ls_gate;
    assign soft_start_restart    = start_q;
    assign discharge_en          = dis_q;
    assign output_good_flag_out  = 1'b0;
    assign output_good_flag_oe_n = pg_q;
    assign overvoltage_latch     = (state_q == bps_pkg::ST_OV);
    assign undervoltage_latch    = (state_q == bps_pkg::ST_UV);
endmodule // bps_sequencer

// ==== inc/bps_pkg.sv ====
// Purpose: constants and types for the buck protection sequencer
// Assumes: 50 MHz system clock, 1 us internal timebase
// Notes:   qualification delays are counted in timebase ticks
package bps_pkg;
    // clock and timebase
    localparam int CLK_HZ       = 50_000_000;
    localparam int TICK_US      = 1;
    localparam int TICK_CYC     = CLK_HZ / 1_000_000 * TICK_US;
    localparam int TICK_W       = 6;
    // qualification delays in microseconds
    localparam int OV_DELAY_US  = 10;
    localparam int UV_DELAY_US  = 100;
    localparam int PG_RISE_US   = 50;
    localparam int PG_FALL_US   = 10;
    localparam int QCNT_W       = 7;
    localparam logic [QCNT_W-1:0] OV_TICKS  = QCNT_W'(OV_DELAY_US / TICK_US);
    localparam logic [QCNT_W-1:0] UV_TICKS  = QCNT_W'(UV_DELAY_US / TICK_US);
    localparam logic [QCNT_W-1:0] PGR_TICKS = QCNT_W'(PG_RISE_US / TICK_US);
    localparam logic [QCNT_W-1:0] PGF_TICKS = QCNT_W'(PG_FALL_US / TICK_US);
    // dead time: least figure, rounded up to whole cycles
    localparam int DEAD_MIN_NS  = 10;
    localparam int DEAD_TYP_NS  = 20;
    localparam int DEAD_CYC_I   = (DEAD_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int DEAD_W       = 4;
    localparam logic [DEAD_W-1:0] DEAD_CYC = DEAD_W'((DEAD_CYC_I < 1) ? 1 : DEAD_CYC_I);
    // synchronised input vector positions
    localparam int IN_EN        = 0;
    localparam int IN_SUPPLY    = 1;
    localparam int IN_OV        = 2;
    localparam int IN_UV        = 3;
    localparam int IN_VALLEY_CURRENT_LIMIT      = 4;
    localparam int IN_THERM     = 5;
    localparam int IN_PG        = 6;
    localparam int IN_W         = 7;

    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_LOCKOUT = 6'h02,
        ST_RUN     = 6'h04,
        ST_OV      = 6'h08,
        ST_UV      = 6'h10,
        ST_THERM   = 6'h20
    } bps_state_type;
endpackage

// ==== inc/bps_gate_if.sv ====
// Purpose: gate request and gate command between sequencer and dead-time stage
// Assumes: one clock domain
// Notes:   requests are levels, gates come from flip-flops
interface bps_gate_if;
    logic hs_req;
    logic ls_req;
    logic hs_gate;
    logic ls_gate;

    modport ctrl
    (
        output hs_req,
        output ls_req,
        input  hs_gate,
        input  ls_gate
    );

    modport dead
    (
        input  hs_req,
        input  ls_req,
        output hs_gate,
        output ls_gate
    );
endinterface

// ==== design/bps_dead_time.sv ====
// Purpose: non-overlap stage between gate requests and gate commands
// Assumes: requests come from logic on the same clock
// Notes:   both requests high is treated as both off
module bps_dead_time
(
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rst_n,
    // gate path
    bps_gate_if.dead       g
);
    logic                          hs_q;
    logic                          hs_d;
    logic                          ls_q;
    logic                          ls_d;
    logic [bps_pkg::DEAD_W-1:0]    cnt_q;
    logic [bps_pkg::DEAD_W-1:0]    cnt_d;
    logic                          want_hs;
    logic                          want_ls;

    always_comb
    begin
        want_hs = g.hs_req & ~g.ls_req;
        want_ls = g.ls_req & ~g.hs_req;
        // off at once, on only after gap
        hs_d = want_hs & (hs_q | (~ls_q & (cnt_q == '0)));
        ls_d = want_ls & (ls_q | (~hs_q & (cnt_q == '0)));
        if ((hs_q & ~hs_d) | (ls_q & ~ls_d))
        begin
            cnt_d = bps_pkg::DEAD_CYC;
        end
        else if (cnt_q != '0)
        begin
            cnt_d = cnt_q - 1'b1;
        end
        else
        begin
            cnt_d = cnt_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hs_q  <= 1'b0;
            ls_q  <= 1'b0;
            cnt_q <= '0;
        end
        else
        begin
            hs_q  <= hs_d;
            ls_q  <= ls_d;
            cnt_q <= cnt_d;
        end
    end

    assign g.hs_gate = hs_q;
    assign g.ls_gate = ls_q;
endmodule // bps_dead_time

// ==== testbench/bps_sequencer_sva.sv ====
// Purpose: port checks for the protection sequencer
// Assumes: sees the top ports only
// Notes:   gate checks allow for the dead-time stage lag
module bps_sequencer_sva
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // pins watched
    input wire logic supply_ok,
    input wire logic valley_current_limit,
    input wire logic high_side_gate,
    input wire logic low_side_gate,
    input wire logic soft_start_restart,
    input wire logic discharge_en,
    input wire logic output_good_flag_out,
    input wire logic output_good_flag_oe_n,
    input wire logic overvoltage_latch,
    input wire logic undervoltage_latch
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    chk_no_overlap: assert property (!(high_side_gate && low_side_gate))
        else $error("gates overlap");
    chk_gap_hs_ls: assert property
        ($fell(high_side_gate) |-> !low_side_gate ##1 !low_side_gate)
        else $error("low gate on too soon");
    chk_gap_ls_hs: assert property
        ($fell(low_side_gate) |-> !high_side_gate ##1 !high_side_gate)
        else $error("high gate on too soon");
    chk_ov_gates: assert property
        (overvoltage_latch [*6] |-> !high_side_gate && low_side_gate)
        else $error("over-voltage gate state wrong");
    chk_uv_gates: assert property
        (undervoltage_latch [*3] |-> !high_side_gate && !low_side_gate)
        else $error("under-voltage gate state wrong");
    chk_therm_gates: assert property
        (discharge_en [*3] |-> !high_side_gate && !low_side_gate)
        else $error("gates on during discharge");
    chk_lockout_off: assert property
        ((!supply_ok && !overvoltage_latch) [*6] |-> !high_side_gate && !low_side_gate)
        else $error("gates on in lockout");
    chk_valley_current_limit_hs: assert property (valley_current_limit [*6] |-> !high_side_gate)
        else $error("high gate on above limit");
    chk_latch_excl: assert property (!(overvoltage_latch && undervoltage_latch))
        else $error("both latches set");
    chk_ss_pulse: assert property (soft_start_restart |=> !soft_start_restart)
        else $error("restart pulse too long");
    chk_pg_fault: assert property
        ((overvoltage_latch || undervoltage_latch || discharge_en) [*2] |-> !output_good_flag_oe_n)
        else $error("flag released in fault");
    chk_pg_zero: assert property (output_good_flag_out == 1'b0)
        else $error("flag drive value not low");
endmodule // bps_sequencer_sva

// ==== testbench/bps_power_stage.sv ====
// Purpose: half-bridge and power-good line seen from outside
// Assumes: gate commands active high
// Notes:   counts turn-ons and any shoot-through
module bps_power_stage
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // device pins
    input  wire logic        hs_gate,
    input  wire logic        ls_gate,
    input  wire logic        pg_out,
    input  wire logic        pg_oe_n,
    // observed
    output wire logic        pg_pin,
    output logic      [15:0] hs_on,
    output logic      [15:0] ls_on,
    output logic      [15:0] shoot
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hs_p;
    logic ls_p;
    assign pg_pin = pg_oe_n ? 1'b1 : pg_out;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {hs_p, ls_p, hs_on, ls_on, shoot} <= '0;
        end
        else
        begin
            hs_p <= hs_gate;
            ls_p <= ls_gate;
            hs_on <= hs_on + 16'(hs_gate && !hs_p);
            ls_on <= ls_on + 16'(ls_gate && !ls_p);
            shoot <= shoot + 16'(hs_gate && ls_gate);
        end
    end
endmodule // bps_power_stage

// ==== testbench/tb_bps_sequencer.sv ====
// Purpose: self-checking bench for the protection sequencer
// Assumes: 50 MHz clock, inputs driven at falling edge
// Notes:   timings measured in cycles against timebase figures
module tb_bps_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, reset_n = 1'b0, en = 1'b0, sup = 1'b1, ov = 1'b0;
    logic uv = 1'b0, lim = 1'b0, th = 1'b0, abv = 1'b0, pwm = 1'b0;
    wire logic hs, ls, ss, dis, pgo, pgoe_n, ovl, uvl, pg_pin;
    logic [15:0] hs_n, ls_n, shoot;
    logic [5:0] obs;
    logic [31:0] rnd = 32'h8e29;
    int failures = 0;
    int samples_checked = 0;
    int n;
    assign obs = {hs, pg_pin, dis, uvl, ovl, ss};
    always #10 sys_clk = ~sys_clk;

    bps_sequencer u_bps_sequencer (.sys_clk(sys_clk), .reset_n(reset_n), .enable(en),
        .supply_ok(sup), .overvoltage_det(ov), .undervoltage_det(uv),
        .valley_current_limit(lim), .thermal_shutdown(th), .output_above_good(abv),
        .pwm_high_req(pwm), .high_side_gate(hs), .low_side_gate(ls),
        .soft_start_restart(ss), .discharge_en(dis), .output_good_flag_out(pgo),
        .output_good_flag_oe_n(pgoe_n), .overvoltage_latch(ovl), .undervoltage_latch(uvl));
    bps_power_stage u_bps_power_stage (.clk(sys_clk), .rst_n(reset_n), .hs_gate(hs),
        .ls_gate(ls), .pg_out(pgo), .pg_oe_n(pgoe_n), .pg_pin(pg_pin), .hs_on(hs_n),
        .ls_on(ls_n), .shoot(shoot));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic int lo_cyc(input int us);
        return us * bps_pkg::TICK_CYC - 10;
    endfunction
    function automatic int hi_cyc(input int us);
        return (us + 1) * bps_pkg::TICK_CYC + 10;
    endfunction
    task automatic complete_run();
        if (failures == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp_bit(input string nm, input logic e, input logic s);
        samples_checked++;
        if (s !== e)
        begin
            failures++;
            $display("MISMATCH %s exp %b seen %b", nm, e, s);
        end
    endtask
    task automatic cmp_rng(input string nm, input int lo, input int hi, input int s);
        samples_checked++;
        if (s < lo || s > hi)
        begin
            failures++;
            $display("MISMATCH %s exp %0d..%0d seen %0d", nm, lo, hi, s);
        end
    endtask
    // waits for obs[sel] to reach lvl, one count per cycle, looked at on falling edge
    task automatic wait_for(input int sel, input logic lvl, input int bound, output int c);
        c = 0;
        do
        begin
            @(negedge sys_clk);
            c++;
            if (c > bound)
            begin
                failures++;
                $display("MISMATCH wait %0d exp %b seen timeout", sel, lvl);
                complete_run();
            end
        end while (obs[sel] !== lvl);
    endtask
    task automatic restart(input string nm);
        wait_for(0, 1'b1, 20, n);
        cmp_rng(nm, 3, 7, n);
    endtask

    initial
    begin
        repeat (10) @(negedge sys_clk);
        cmp_bit("pg_rst", 1'b0, pg_pin);
        cmp_bit("hs_rst", 1'b0, hs);
        reset_n = 1'b1;
        repeat (6) @(negedge sys_clk);
        en = 1'b1;
        restart("ss_enable");
        // random switching with current limit events
        repeat (400)
        begin
            @(negedge sys_clk);
            rnd = lfsr(rnd);
            pwm = rnd[0];
            lim = (rnd[6:4] == 3'h0);
            repeat (rnd[3:0] + 3) @(negedge sys_clk);
        end
        cmp_bit("no_latch", 1'b0, ovl | uvl);
        cmp_bit("hs_switch", 1'b1, hs_n != 16'h0);
        cmp_bit("ls_switch", 1'b1, ls_n != 16'h0);
        cmp_bit("no_shoot", 1'b1, shoot == 16'h0);
        @(negedge sys_clk) {pwm, lim} = 2'b11;
        repeat (20) @(negedge sys_clk);
        cmp_bit("hs_lim", 1'b0, hs);
        cmp_bit("ls_lim", 1'b1, ls);
        lim = 1'b0;
        wait_for(5, 1'b1, 10, n);
        // output-good with a dropout that must restart the count
        abv = 1'b1;
        repeat (40 * bps_pkg::TICK_CYC) @(negedge sys_clk);
        abv = 1'b0;
        repeat (3 * bps_pkg::TICK_CYC) @(negedge sys_clk);
        cmp_bit("pg_early", 1'b0, pg_pin);
        abv = 1'b1;
        wait_for(4, 1'b1, hi_cyc(50), n);
        cmp_rng("pg_rise", lo_cyc(bps_pkg::PG_RISE_US), hi_cyc(50), n);
        @(negedge sys_clk) abv = 1'b0;
        wait_for(4, 1'b0, hi_cyc(10), n);
        cmp_rng("pg_fall", lo_cyc(bps_pkg::PG_FALL_US), hi_cyc(10), n);
        // short over-voltage glitch, then a held one
        abv = 1'b1;
        @(negedge sys_clk) ov = 1'b1;
        repeat (5 * bps_pkg::TICK_CYC) @(negedge sys_clk);
        ov = 1'b0;
        repeat (4) @(negedge sys_clk);
        cmp_bit("ov_glitch", 1'b0, ovl);
        ov = 1'b1;
        wait_for(1, 1'b1, hi_cyc(10), n);
        cmp_rng("ov_delay", lo_cyc(bps_pkg::OV_DELAY_US), hi_cyc(10), n);
        @(negedge sys_clk) {ov, sup} = 2'b00;
        repeat (200) @(negedge sys_clk);
        cmp_bit("ov_hold", 1'b1, ovl);
        cmp_bit("ov_ls", 1'b1, ls);
        cmp_bit("ov_pg", 1'b0, pg_pin);
        {sup, en} = 2'b10;
        wait_for(1, 1'b0, 20, n);
        @(negedge sys_clk) en = 1'b1;
        restart("ss_ov");
        @(negedge sys_clk) uv = 1'b1;
        wait_for(2, 1'b1, hi_cyc(100), n);
        cmp_rng("uv_delay", lo_cyc(bps_pkg::UV_DELAY_US), hi_cyc(100), n);
        repeat (4) @(negedge sys_clk);
        cmp_bit("uv_gates", 1'b0, hs | ls);
        {uv, en} = 2'b00;
        wait_for(2, 1'b0, 20, n);
        @(negedge sys_clk) en = 1'b1;
        restart("ss_uv");
        @(negedge sys_clk) th = 1'b1;
        wait_for(3, 1'b1, 20, n);
        repeat (300) @(negedge sys_clk);
        cmp_bit("th_gates", 1'b0, hs | ls);
        cmp_bit("th_dis", 1'b1, dis);
        th = 1'b0;
        restart("ss_therm");
        cmp_bit("th_dis_off", 1'b0, dis);
        repeat (20) @(negedge sys_clk);
        sup = 1'b0;
        repeat (8) @(negedge sys_clk);
        cmp_bit("lock_gates", 1'b0, hs | ls);
        sup = 1'b1;
        restart("ss_supply");
        complete_run();
    end
endmodule // tb_bps_sequencer

bind bps_sequencer bps_sequencer_sva u_bps_sequencer_sva (.sys_clk, .reset_n, .supply_ok,
    .valley_current_limit, .high_side_gate, .low_side_gate, .soft_start_restart,
    .discharge_en, .output_good_flag_out, .output_good_flag_oe_n, .overvoltage_latch,
    .undervoltage_latch);
